// *** hbc_bridge_dec.sv ***
// Purpose: decodes one bridge's mode, PWM and chopper phase into switch states
// Assumes: inputs already synchronised
// Notes: purely combinational
`timescale 1ns/1ps
module hbc_bridge_dec (
   hbc_bridge_if.dec br // Bridge controls and switch states
);
   import hbc_pkg::*;
   logic fwd;
   logic rev;
   logic brake;
   logic decay_slow;
   logic decay_fast;

   assign fwd = !br.standby && br.pwm && br.dir1 && !br.dir2;
   assign rev = !br.standby && br.pwm && !br.dir1 && br.dir2;
   // PWM low with a mode bit set, or both mode bits set: short brake
   assign brake = !br.standby && (br.dir1 || br.dir2) && !(fwd || rev);
   assign decay_slow = br.chop_en && (br.phase == HBC_SLOW);
   assign decay_fast = br.chop_en && (br.phase == HBC_FAST);

   // Fast decay swaps the diagonal; slow decay is both low switches
   assign br.high_switch_1 = (fwd && !decay_slow && !decay_fast) || (rev && decay_fast);
   assign br.high_switch_2 = (rev && !decay_slow && !decay_fast) || (fwd && decay_fast);
   assign br.low_switch_1 = brake || ((fwd || rev) && decay_slow) || (rev && !decay_slow && !decay_fast)
                            || (fwd && decay_fast);
   assign br.low_switch_2 = brake || ((fwd || rev) && decay_slow) || (fwd && !decay_slow && !decay_fast)
                            || (rev && decay_fast);
endmodule : hbc_bridge_dec

// *** hbc_bridge_if.sv ***
// Purpose: carries one bridge's controls to its decoder and the switch states back
// Assumes: all signals on pclk
// Notes: switch outputs are combinational
`timescale 1ns/1ps
interface hbc_bridge_if;
   import hbc_pkg::*;
   logic dir1;
   logic dir2;
   logic pwm;
   logic standby;
   logic chop_en;
   hbc_phase_t phase;
   logic high_switch_1;
   logic high_switch_2;
   logic low_switch_1;
   logic low_switch_2;
   modport ctl (output dir1, dir2, pwm, standby, chop_en, phase,
                input high_switch_1, high_switch_2, low_switch_1, low_switch_2);
   modport dec (input dir1, dir2, pwm, standby, chop_en, phase,
                output high_switch_1, high_switch_2, low_switch_1, low_switch_2);
endinterface : hbc_bridge_if

// *** hbc_host_model.sv ***
// Purpose: host model driving bridge pins, selects, chopper oscillator and limit comparators
// Assumes: pins change just after a rising pclk edge
// Notes: oscillator period is 8 pclk, generated from pclk so periods repeat exactly
`timescale 1ns/1ps
module hbc_host_model (
   input wire logic pclk, // Clock
   output logic [2:0] a_pins, // Bridge A {pwm, dir1, dir2}
   output logic [2:0] b_pins, // Bridge B {pwm, dir1, dir2}
   output logic bsel, // Blanking length select
   output logic gang, // Combined bridge select
   output logic osc, // Chopper oscillator
   output logic [1:0] limit // Current limit comparators
);
   logic [1:0] div_q;
   logic osc_on;

   initial begin
      a_pins = 3'h0;
      b_pins = 3'h0;
      bsel = 1'b0;
      gang = 1'b0;
      osc = 1'b0;
      limit = 2'h0;
      div_q = 2'h0;
      osc_on = 1'b0;
   end

   // ==========================================
   // Oscillator, well below pclk/4
   always @(posedge pclk) begin
      if (osc_on) begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3) begin
            osc <= ~osc;
         end
      end
   end

   // ==========================================
   // Host actions
   task automatic drive_pins(input logic [2:0] a, input logic [2:0] b, input logic break_b);
      @(posedge pclk);
      a_pins <= a;
      b_pins <= (gang && !break_b) ? 3'h0 : b;
   endtask : drive_pins

   // Gang level changes only while the device is held in reset
   task automatic set_sel(input logic bs, input logic g);
      @(posedge pclk);
      bsel <= bs;
      gang <= g;
   endtask : set_sel

   task automatic set_osc_limit(input logic on, input logic [1:0] lim);
      @(posedge pclk);
      osc_on <= on;
      limit <= lim;
   endtask : set_osc_limit
endmodule : hbc_host_model

// *** hbc_pkg.sv ***
// Purpose: shared constants and types of the dual H-bridge chopper control
// Assumes: 50 MHz pclk, chopper oscillator arriving as a pin
// Notes: register offsets are byte addresses on a 32-bit APB
package hbc_pkg;

   // ==========================================
   // Register map
   localparam logic [11:0] HBC_CTRL_OFS = 12'h000;
   localparam logic [11:0] HBC_STATUS_OFS = 12'h004;
   localparam logic [11:0] HBC_COUNT_OFS = 12'h008;
   localparam int HBC_CTRL_CHOP_EN_BIT = 0;
   localparam logic [31:0] HBC_CTRL_RST = 32'h0000_0001;

   // ==========================================
   // Chopper timing
   localparam logic [3:0] HBC_PERIOD_LAST = 4'hF;
   // Counter value at the tick that starts the last six of sixteen clocks
   localparam logic [3:0] HBC_FAST_TICK = 4'h9;
   localparam logic [2:0] HBC_BLANK_SHORT = 3'h4;
   localparam logic [2:0] HBC_BLANK_LONG = 3'h6;
   localparam int HBC_CLK_NS = 20;
   localparam int HBC_ANA_BLANK_NS = 400;
   localparam int HBC_ANA_BLANK_CYC_I = (HBC_ANA_BLANK_NS + HBC_CLK_NS - 1) / HBC_CLK_NS;
   localparam logic [4:0] HBC_ANA_BLANK_CYC = 5'(HBC_ANA_BLANK_CYC_I);

   // ==========================================
   // Chopper phase, one-hot
   typedef enum logic [2:0] {
      HBC_CHARGE = 3'b001,
      HBC_SLOW = 3'b010,
      HBC_FAST = 3'b100
   } hbc_phase_t;

endpackage : hbc_pkg

// *** hbc_sync.sv ***
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are quasi-static relative to pclk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module hbc_sync #(
   parameter int WIDTH = 11
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, active low
   input wire logic [WIDTH-1:0] din, // Asynchronous pins
   output logic [WIDTH-1:0] dout // Synchronised copy
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule : hbc_sync

// *** hbc_top.sv ***
// Purpose: dual H-bridge control with constant-current chopper and APB registers
// Assumes: pclk 50 MHz; all bridge pins asynchronous to pclk
// Notes: outputs are level plus enable; enable low means the pin floats
// Operation
// - Bridge A with PWM high decodes stop, reverse, forward from its mode pair.
// - Bridge B decodes its own mode pair and PWM the same way.
// - Standby, all outputs off, only when all six bridge inputs are low (only bridge A's three in combined mode).
// - Standby ends as soon as any of the six inputs is high (any of bridge A's three in combined mode).
// - Digital blanking lasts 4 oscillator clocks, or 6 when blank select is high.
// - Blanking starts at each charge start and on any mode-bit change.
// - Current-limit detection is ignored while blanking is active.
// - A fixed analog blanking of about 400 ns also masks detection.
// - Gang select low gives two bridges, high gives one combined bridge.
// - Independent mode drives each bridge from its own inputs.
// - Combined mode uses only bridge A inputs; bridge B inputs are ignored.
// - Blank select works in both bridge modes.
// - Fast decay takes the final 37.5 percent of each chopping period.
// - Each period starts in charge as the oscillator counter restarts at zero.
// - Current-limit detection during charge switches to slow decay.
// - Slow decay becomes fast decay on the eleventh oscillator clock.
// - After 16 oscillator clocks the counter resets and charge restarts.
// - Forward: charge high1+low2, slow both lows, fast high2+low1.
// - Reverse: charge high2+low1, slow both lows, fast high1+low2.
`timescale 1ns/1ps
module hbc_top (
   input wire logic pclk, // APB clock
   input wire logic presetn, // Async reset, active low
   input wire logic [11:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic bridge_a_dir_in1, // Bridge A mode 1
   input wire logic bridge_a_dir_in2, // Bridge A mode 2
   input wire logic bridge_a_pwm_in, // Bridge A PWM
   input wire logic bridge_b_dir_in1, // Bridge B mode 1
   input wire logic bridge_b_dir_in2, // Bridge B mode 2
   input wire logic bridge_b_pwm_in, // Bridge B PWM
   input wire logic blank_time_select, // Blanking length select
   input wire logic bridge_gang_select, // Combined bridge select
   input wire logic chop_osc_clock, // Chopper oscillator
   input wire logic [1:0] current_limit_detect, // Per-bridge current limit comparator
   output logic bridge_a_out_pos, // Bridge A positive level
   output logic bridge_a_out_pos_oe, // Bridge A positive enable
   output logic bridge_a_out_neg, // Bridge A negative level
   output logic bridge_a_out_neg_oe, // Bridge A negative enable
   output logic bridge_b_out_pos, // Bridge B positive level
   output logic bridge_b_out_pos_oe, // Bridge B positive enable
   output logic bridge_b_out_neg, // Bridge B negative level
   output logic bridge_b_out_neg_oe // Bridge B negative enable
);
   import hbc_pkg::*;

   // ==========================================
   // Input synchronisation
   logic [10:0] pins_s;
   hbc_sync #(.WIDTH(11)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({bridge_a_dir_in1, bridge_a_dir_in2, bridge_a_pwm_in, bridge_b_dir_in1, bridge_b_dir_in2,
            bridge_b_pwm_in, blank_time_select, bridge_gang_select, chop_osc_clock, current_limit_detect}),
      .dout(pins_s)
   );

   wire a_dir1 = pins_s[10];
   wire a_dir2 = pins_s[9];
   wire a_pwm = pins_s[8];
   wire gang = pins_s[3];
   wire blank_sel = pins_s[4];
   wire osc_s = pins_s[2];
   // Bridge B pins are forced out of the picture when ganged
   wire b_dir1 = pins_s[7] && !gang;
   wire b_dir2 = pins_s[6] && !gang;
   wire b_pwm = pins_s[5] && !gang;
   wire [1:0] limit_s = {pins_s[1] && !gang, pins_s[0]};
   wire standby_w = !(a_dir1 || a_dir2 || a_pwm || b_dir1 || b_dir2 || b_pwm);

   // ==========================================
   // Control register
   logic [31:0] ctrl_q;
   wire chop_en = ctrl_q[HBC_CTRL_CHOP_EN_BIT];

   // ==========================================
   // Oscillator edge and period counter
   logic osc_prev_q;
   logic [3:0] cnt_q;
   logic [3:0] dir_prev_q;
   wire tick = osc_s && !osc_prev_q;
   wire period_start = tick && (cnt_q == HBC_PERIOD_LAST);
   wire fast_start = tick && (cnt_q == HBC_FAST_TICK);
   wire [3:0] dir_now = {a_dir1, a_dir2, b_dir1, b_dir2};
   wire dir_chg = dir_now != dir_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_prev_q <= 1'b0;
         cnt_q <= 4'h0;
         dir_prev_q <= 4'h0;
      end else begin
         osc_prev_q <= osc_s;
         dir_prev_q <= dir_now;
         if (tick) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   // ==========================================
   // Blanking: digital in oscillator clocks, analog in pclk cycles
   logic [2:0] blank_dig_q;
   logic [4:0] blank_ana_q;
   wire blank_load = period_start || dir_chg;
   wire [2:0] blank_len = blank_sel ? HBC_BLANK_LONG : HBC_BLANK_SHORT;
   wire blank_act = (blank_dig_q != 3'h0) || (blank_ana_q != 5'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_dig_q <= 3'h0;
         blank_ana_q <= 5'h0;
      end else if (blank_load) begin
         blank_dig_q <= blank_len;
         blank_ana_q <= HBC_ANA_BLANK_CYC;
      end else begin
         if (tick && blank_dig_q != 3'h0) begin
            blank_dig_q <= blank_dig_q - 3'h1;
         end
         if (blank_ana_q != 5'h0) begin
            blank_ana_q <= blank_ana_q - 5'h1;
         end
      end
   end

   // ==========================================
   // Chopper phase per bridge
   hbc_phase_t phase_q [2];

   function automatic hbc_phase_t next_phase(hbc_phase_t cur, logic limit);
      hbc_phase_t nxt;
      nxt = cur;
      if (period_start) begin
         nxt = HBC_CHARGE;
      end else if (fast_start) begin
         nxt = HBC_FAST;
      end else if (cur == HBC_CHARGE && limit && !blank_act) begin
         nxt = HBC_SLOW;
      end
      return nxt;
   endfunction : next_phase

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q[0] <= HBC_CHARGE;
         phase_q[1] <= HBC_CHARGE;
      end else begin
         phase_q[0] <= next_phase(phase_q[0], limit_s[0]);
         phase_q[1] <= next_phase(phase_q[1], limit_s[1]);
      end
   end

   // ==========================================
   // Bridge decoders
   logic [3:0] sw [2];
   wire [2:0] br_in [2];
   assign br_in[0] = {a_dir1, a_dir2, a_pwm};
   assign br_in[1] = {b_dir1, b_dir2, b_pwm};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_br
         hbc_bridge_if bif();
         assign bif.dir1 = br_in[gi][2];
         assign bif.dir2 = br_in[gi][1];
         assign bif.pwm = br_in[gi][0];
         assign bif.standby = standby_w;
         assign bif.chop_en = chop_en;
         assign bif.phase = phase_q[gi];
         assign sw[gi] = {bif.high_switch_1, bif.high_switch_2, bif.low_switch_1, bif.low_switch_2};
         hbc_bridge_dec u_dec (
            .br(bif)
         );
      end
   endgenerate

   // ==========================================
   // Output pins, combined mode pairs A pins and B pins
   wire l_pos = sw[0][3];
   wire l_pos_oe = sw[0][3] || sw[0][1];
   wire l_neg = sw[0][2];
   wire l_neg_oe = sw[0][2] || sw[0][0];
   wire b_pos_d = gang ? l_neg : sw[1][3];
   wire b_pos_oe_d = gang ? l_neg_oe : (sw[1][3] || sw[1][1]);
   wire b_neg_d = gang ? l_neg : sw[1][2];
   wire b_neg_oe_d = gang ? l_neg_oe : (sw[1][2] || sw[1][0]);
   wire a_neg_d = gang ? l_pos : l_neg;
   wire a_neg_oe_d = gang ? l_pos_oe : l_neg_oe;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_a_out_pos <= 1'b0;
         bridge_a_out_pos_oe <= 1'b0;
         bridge_a_out_neg <= 1'b0;
         bridge_a_out_neg_oe <= 1'b0;
         bridge_b_out_pos <= 1'b0;
         bridge_b_out_pos_oe <= 1'b0;
         bridge_b_out_neg <= 1'b0;
         bridge_b_out_neg_oe <= 1'b0;
      end else begin
         bridge_a_out_pos <= l_pos;
         bridge_a_out_pos_oe <= l_pos_oe;
         bridge_a_out_neg <= a_neg_d;
         bridge_a_out_neg_oe <= a_neg_oe_d;
         bridge_b_out_pos <= b_pos_d;
         bridge_b_out_pos_oe <= b_pos_oe_d;
         bridge_b_out_neg <= b_neg_d;
         bridge_b_out_neg_oe <= b_neg_oe_d;
      end
   end

   // ==========================================
   // APB slave, zero wait states
   wire acc = psel && penable;
   wire hit_ctrl = paddr == HBC_CTRL_OFS;
   wire hit_status = paddr == HBC_STATUS_OFS;
   wire hit_count = paddr == HBC_COUNT_OFS;
   wire hit_any = hit_ctrl || hit_status || hit_count;
   wire [31:0] status_w = {16'h0000, 5'h00, phase_q[1], phase_q[0], gang, blank_act, standby_w,
                           bridge_a_out_pos, bridge_a_out_neg};
   wire [31:0] count_w = {24'h00_0000, 1'b0, blank_dig_q, cnt_q};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_q : hit_status ? status_w : hit_count ? count_w : 32'h0000_0000;

   assign pready = 1'b1;
   assign pslverr = acc && !hit_any;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= HBC_CTRL_RST;
         prdata <= 32'h0000_0000;
      end else begin
         if (acc && pwrite && hit_ctrl) begin
            ctrl_q <= {31'h0000_0000, pwdata[HBC_CTRL_CHOP_EN_BIT]};
         end
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_a_forward;
      !gang && a_pwm && a_dir1 && !a_dir2 && !chop_en |=>
         bridge_a_out_pos_oe && bridge_a_out_pos && bridge_a_out_neg_oe && !bridge_a_out_neg;
   endproperty
   a_a_forward: assert property (p_a_forward) else $error("bridge A forward decode wrong");

   property p_b_reverse;
      !gang && b_pwm && !b_dir1 && b_dir2 && !chop_en |=>
         bridge_b_out_pos_oe && !bridge_b_out_pos && bridge_b_out_neg_oe && bridge_b_out_neg;
   endproperty
   a_b_reverse: assert property (p_b_reverse) else $error("bridge B reverse decode wrong");

   property p_a_brake;
      !gang && !a_pwm && (a_dir1 || a_dir2) |=>
         bridge_a_out_pos_oe && !bridge_a_out_pos && bridge_a_out_neg_oe && !bridge_a_out_neg;
   endproperty
   a_a_brake: assert property (p_a_brake) else $error("short brake not driven");

   property p_standby;
      standby_w |=> !(bridge_a_out_pos_oe || bridge_a_out_neg_oe || bridge_b_out_pos_oe || bridge_b_out_neg_oe);
   endproperty
   a_standby: assert property (p_standby) else $error("output enabled in standby");

   property p_blank_len;
      blank_load |=> blank_dig_q == ($past(blank_sel) ? 3'h6 : 3'h4);
   endproperty
   a_blank_len: assert property (p_blank_len) else $error("digital blank length wrong");

   property p_ana_blank;
      // A mode-bit change right after the period start reloads the count
      period_start |=> blank_ana_q == 5'd20 ##1 (blank_ana_q == 5'd19 || $past(blank_load));
   endproperty
   a_ana_blank: assert property (p_ana_blank) else $error("analog blank not 400 ns");

   property p_blank_holds;
      phase_q[0] == HBC_CHARGE && blank_act && !period_start && !fast_start |=> phase_q[0] == HBC_CHARGE;
   endproperty
   a_blank_holds: assert property (p_blank_holds) else $error("limit acted during blanking");

   property p_gang_pair;
      gang && $past(gang) |-> bridge_b_out_pos == bridge_b_out_neg && bridge_a_out_pos == bridge_a_out_neg;
   endproperty
   a_gang_pair: assert property (p_gang_pair) else $error("combined pins differ");

   property p_fast_at_11;
      fast_start |=> phase_q[0] == HBC_FAST && phase_q[1] == HBC_FAST && cnt_q == 4'hA;
   endproperty
   a_fast_at_11: assert property (p_fast_at_11) else $error("fast decay not at 11th clock");

   property p_period_wrap;
      period_start |=> cnt_q == 4'h0 && phase_q[0] == HBC_CHARGE;
   endproperty
   a_period_wrap: assert property (p_period_wrap) else $error("period did not restart charge");

   property p_fwd_slow;
      chop_en && !gang && a_pwm && a_dir1 && !a_dir2 && phase_q[0] == HBC_SLOW |=>
         !bridge_a_out_pos && !bridge_a_out_neg && bridge_a_out_pos_oe && bridge_a_out_neg_oe;
   endproperty
   a_fwd_slow: assert property (p_fwd_slow) else $error("slow decay switches wrong");

   c_slow: cover property (phase_q[0] == HBC_CHARGE ##1 phase_q[0] == HBC_SLOW);
   c_gang: cover property (gang && a_pwm && a_dir1);
   c_wrap: cover property (period_start);
endmodule : hbc_top

// *** tb_hbc_top.sv ***
// Purpose: self-checking bench for the dual H-bridge control
// Assumes: zero-wait APB, outputs follow pins within 3 pclk edges
// Notes: chopper checked by counting output states over whole periods
`timescale 1ns/1ps
module tb_hbc_top;
   import hbc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [2:0] a_pins, b_pins;
   logic bsel, gang, osc;
   logic [1:0] limit;
   logic ap, ape, an, ane, bp, bpe, bn, bne;
   logic [31:0] rd;
   logic err;
   int n_mismatch = 0;
   int comparisons = 0;
   int c4, c6, nc, nf, ns;

   always #10 pclk = ~pclk;

   hbc_host_model hbc_host_model_i (.pclk(pclk), .a_pins(a_pins), .b_pins(b_pins), .bsel(bsel),
      .gang(gang), .osc(osc), .limit(limit));

   hbc_top hbc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bridge_a_dir_in1(a_pins[1]), .bridge_a_dir_in2(a_pins[0]), .bridge_a_pwm_in(a_pins[2]),
      .bridge_b_dir_in1(b_pins[1]), .bridge_b_dir_in2(b_pins[0]), .bridge_b_pwm_in(b_pins[2]),
      .blank_time_select(bsel), .bridge_gang_select(gang), .chop_osc_clock(osc),
      .current_limit_detect(limit), .bridge_a_out_pos(ap), .bridge_a_out_pos_oe(ape),
      .bridge_a_out_neg(an), .bridge_a_out_neg_oe(ane), .bridge_b_out_pos(bp), .bridge_b_out_pos_oe(bpe),
      .bridge_b_out_neg(bn), .bridge_b_out_neg_oe(bne));

   // ==========================================
   // Helpers
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Off shows only the enables; a floating level is not compared
   function automatic logic [3:0] dec(input logic [2:0] v);
      if (v[1:0] == 2'b00) return 4'b0000;
      if (!v[2] || v[1:0] == 2'b11) return 4'b1010;
      return (v[1:0] == 2'b10) ? 4'b1110 : 4'b1011;
   endfunction : dec

   function automatic logic [31:0] obs_a();
      return {28'h0, ape, ape & ap, ane, ane & an};
   endfunction : obs_a

   function automatic logic [31:0] obs_b();
      return {28'h0, bpe, bpe & bp, bne, bne & bn};
   endfunction : obs_b

   // Gang select is moved only while reset is held
   task automatic pulse_reset(input logic g);
      @(posedge pclk);
      presetn <= 1'b0;
      hbc_host_model_i.set_sel(1'b0, g);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask : pulse_reset

   // Four whole chopping periods of 128 pclk each
   task automatic measure(input logic [3:0] chg, input logic [3:0] fst);
      nc = 0;
      nf = 0;
      ns = 0;
      repeat (512) begin
         @(negedge pclk);
         nc += (obs_a() === {28'h0, chg});
         nf += (obs_a() === {28'h0, fst});
         ns += (obs_a() === 32'h0000_000A);
      end
   endtask : measure

   initial begin
      #400000;
      n_mismatch++;
      print_verdict();
   end

   // ==========================================
   // Tests
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(HBC_CTRL_OFS, 1'b0, 32'h0);
      check(rd, HBC_CTRL_RST);
      check({31'h0, err}, 32'h0);
      apb(12'h00C, 1'b0, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(HBC_CTRL_OFS, 1'b1, 32'hFFFF_FFFE);
      apb(HBC_CTRL_OFS, 1'b0, 32'h0);
      check(rd, 32'h0);
      // Direct PWM decode on each bridge, the other stopped
      for (int i = 0; i < 16; i++) begin
         if (i < 8) hbc_host_model_i.drive_pins(3'(i), 3'b100, 1'b0);
         else hbc_host_model_i.drive_pins(3'b100, 3'(i), 1'b0);
         repeat (5) @(posedge pclk);
         check(i < 8 ? obs_a() : obs_b(), {28'h0, dec(3'(i))});
         check(i < 8 ? obs_b() : obs_a(), 32'h0);
      end
      for (int k = 0; k < 7; k++) begin
         hbc_host_model_i.drive_pins(3'(k == 0 ? 6'h0 : 6'h1 << (k - 1)), 3'((6'h1 << (k - 1)) >> 3), 1'b0);
         repeat (5) @(posedge pclk);
         apb(HBC_STATUS_OFS, 1'b0, 32'h0);
         check({31'h0, rd[2]}, {31'h0, k == 0});
      end
      // Combined bridge, B pins deliberately driven against the host rule
      pulse_reset(1'b1);
      apb(HBC_CTRL_OFS, 1'b1, 32'h0);
      for (int d = 0; d < 2; d++) begin
         hbc_host_model_i.drive_pins(d ? 3'b101 : 3'b110, d ? 3'b110 : 3'b101, 1'b1);
         repeat (5) @(posedge pclk);
         check(obs_a(), d ? 32'hA : 32'hF);
         check(obs_b(), d ? 32'hF : 32'hA);
      end
      apb(HBC_STATUS_OFS, 1'b0, 32'h0);
      check({31'h0, rd[4]}, 32'h1);
      pulse_reset(1'b0);
      // Constant-current chopping, forward then reverse
      for (int d = 0; d < 2; d++) begin
         hbc_host_model_i.drive_pins(d ? 3'b101 : 3'b110, 3'b100, 1'b0);
         hbc_host_model_i.set_osc_limit(1'b1, 2'b00);
         repeat (256) @(posedge pclk);
         measure(d ? 4'hB : 4'hE, d ? 4'hE : 4'hB);
         check(32'(nf), 32'd192);
         check(32'(nc), 32'd320);
         hbc_host_model_i.set_osc_limit(1'b1, 2'b11);
         repeat (256) @(posedge pclk);
         measure(d ? 4'hB : 4'hE, d ? 4'hE : 4'hB);
         c4 = nc;
         check(32'(nf), 32'd192);
         check(32'(ns > 0), 32'h1);
         check(32'(c4 >= 128), 32'h1);
         hbc_host_model_i.set_sel(1'b1, 1'b0);
         repeat (256) @(posedge pclk);
         measure(d ? 4'hB : 4'hE, d ? 4'hE : 4'hB);
         c6 = nc;
         check(32'(c6 - c4), 32'd64);
         hbc_host_model_i.set_sel(1'b0, 1'b0);
      end
      print_verdict();
   end
endmodule : tb_hbc_top
